// ---- rtl/io_data_and_temp_threshold_regs.sv ----
/*
  Register bank for port input/output levels, shared analog-output
  presets, temperature averaging settings and temperature limits.
  Assumes the serial front end presents decoded register accesses
  synchronous to CLK_IN, and port modes and monitor enables come from
  configuration logic elsewhere.
*/
`timescale 1ns/1ps
`include "io_regs_consts.svh"
module io_data_and_temp_threshold_regs
  import io_regs_pkg::*;
#(
  parameter int PORTS = `PORT_N,
  parameter int MONITORS = `MON_N
)
(
  input wire logic CLK_IN, // 50 MHz clock
  input wire logic RST_N_IN, // Async reset, active low
  input wire logic CE_IN, // Clock enable, freezes all state
  input wire reg_req_t REG_REQ_IN, // Register access request
  output logic [`REG_DW-1:0] REG_RDATA_OUT, // Read data
  output logic REG_RVALID_OUT, // Read data valid pulse
  input wire logic [PORTS-1:0] PORT_LEVEL_IN, // Sampled pin levels
  input wire logic [PORTS-1:0] PORT_IS_INPUT_IN, // Input-mode ports
  input wire logic [PORTS-1:0] PORT_IS_OUTPUT_IN, // Output-mode ports
  input wire logic [PORTS-1:0] PORT_IS_ANALOG_IN, // Analog-out ports
  output logic [PORTS-1:0] PORT_DRIVE_OUT, // Pin output level
  output logic [PORTS-1:0] PORT_OE_N_OUT, // Pin enable, low drives
  input wire logic [1:0] ANALOG_MODE_IN, // Analog-output mode select
  output logic [PORTS-1:0] PORT_PRESET_OUT, // Port takes preset
  output temp_t PRESET_DATA_OUT, // Selected preset value
  input wire logic [MONITORS-1:0] MONITOR_ENABLE_IN, // Monitor enables
  input wire temp_sample_t [MONITORS-1:0] TEMP_SAMPLE_IN, // Samples
  output monitor_flags_t [MONITORS-1:0] MONITOR_FLAGS_OUT // Flags
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PORTS-1:0] out_levels;
    temp_t preset_one;
    temp_t preset_two;
    temp_t preset_data;
    logic [MONITORS*`AVG_CODE_W-1:0] avg_cfg;
    temp_limits_t [MONITORS-1:0] limits;
    logic [`REG_DW-1:0] rdata;
    logic rvalid;
  } bank_state_t;

  // Host-visible state; input levels live in the port block
  bank_state_t s_q;
  bank_state_t s_d;
  logic [PORTS-1:0] in_levels;
  logic preset_active;
  temp_t [MONITORS-1:0] mon_result;
  monitor_flags_t [MONITORS-1:0] mon_flags;
  logic [`REG_DW-1:0] read_word;
  logic [PORTS-1:0] wr_out_levels;

  // ---------------------------------------------------------------
  // Shared preset selection
  // ---------------------------------------------------------------
  // Codes 2 and 3 hand every analog port a shared preset
  assign preset_active = (ANALOG_MODE_IN == `MODE_PRESET_ONE) ||
    (ANALOG_MODE_IN == `MODE_PRESET_TWO);

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  // Same-cycle writes are not seen; reads return old state
  always_comb
  begin
    read_word = '0;
    case (REG_REQ_IN.addr)
      `ADDR_IN_LO:
      begin
        read_word = in_levels[`LO_SPLIT-1:0];
      end
      `ADDR_IN_HI:
      begin
        read_word = `REG_DW'(in_levels[PORTS-1:`LO_SPLIT]);
      end
      `ADDR_OUT_LO:
      begin
        read_word = s_q.out_levels[`LO_SPLIT-1:0];
      end
      `ADDR_OUT_HI:
      begin
        read_word = `REG_DW'(s_q.out_levels[PORTS-1:`LO_SPLIT]);
      end
      `ADDR_PRESET_ONE:
      begin
        read_word = `REG_DW'(s_q.preset_one);
      end
      `ADDR_PRESET_TWO:
      begin
        read_word = `REG_DW'(s_q.preset_two);
      end
      `ADDR_AVG_CFG:
      begin
        read_word = `REG_DW'(s_q.avg_cfg);
      end
      `ADDR_INT_HI:
      begin
        read_word = `REG_DW'(s_q.limits[0].high);
      end
      `ADDR_INT_LO:
      begin
        read_word = `REG_DW'(s_q.limits[0].low);
      end
      `ADDR_EXT1_HI:
      begin
        read_word = `REG_DW'(s_q.limits[1].high);
      end
      `ADDR_EXT1_LO:
      begin
        read_word = `REG_DW'(s_q.limits[1].low);
      end
      `ADDR_EXT2_HI:
      begin
        read_word = `REG_DW'(s_q.limits[2].high);
      end
      `ADDR_EXT2_LO:
      begin
        read_word = `REG_DW'(s_q.limits[2].low);
      end
      `ADDR_FLAGS:
      begin
        read_word = `REG_DW'(mon_flags);
      end
      `ADDR_RES_INT:
      begin
        read_word = `REG_DW'(mon_result[0]);
      end
      `ADDR_RES_EXT1:
      begin
        read_word = `REG_DW'(mon_result[1]);
      end
      `ADDR_RES_EXT2:
      begin
        read_word = `REG_DW'(mon_result[2]);
      end
      default:
      begin
        read_word = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Output level write merge
  // ---------------------------------------------------------------
  // Keeps the part of the level word that is not addressed
  always_comb
  begin
    wr_out_levels = s_q.out_levels;
    if (REG_REQ_IN.addr == `ADDR_OUT_LO)
    begin
      wr_out_levels[`LO_SPLIT-1:0] = REG_REQ_IN.wdata;
    end
    else if (REG_REQ_IN.addr == `ADDR_OUT_HI)
    begin
      wr_out_levels[PORTS-1:`LO_SPLIT] =
        REG_REQ_IN.wdata[PORTS-`LO_SPLIT-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Read answer is a one-cycle pulse after the strobe
    s_d.rvalid = REG_REQ_IN.rd;
    if (REG_REQ_IN.rd)
    begin
      s_d.rdata = read_word;
    end
    if (REG_REQ_IN.wr)
    begin
      case (REG_REQ_IN.addr)
        `ADDR_OUT_LO, `ADDR_OUT_HI:
        begin
          s_d.out_levels = wr_out_levels;
        end
        `ADDR_PRESET_ONE:
        begin
          s_d.preset_one = REG_REQ_IN.wdata[`TEMP_W-1:0];
        end
        `ADDR_PRESET_TWO:
        begin
          s_d.preset_two = REG_REQ_IN.wdata[`TEMP_W-1:0];
        end
        `ADDR_AVG_CFG:
        begin
          s_d.avg_cfg =
            REG_REQ_IN.wdata[MONITORS*`AVG_CODE_W-1:0];
        end
        `ADDR_INT_HI:
        begin
          s_d.limits[0].high = REG_REQ_IN.wdata[`TEMP_W-1:0];
        end
        `ADDR_INT_LO:
        begin
          s_d.limits[0].low = REG_REQ_IN.wdata[`TEMP_W-1:0];
        end
        `ADDR_EXT1_HI:
        begin
          s_d.limits[1].high = REG_REQ_IN.wdata[`TEMP_W-1:0];
        end
        `ADDR_EXT1_LO:
        begin
          s_d.limits[1].low = REG_REQ_IN.wdata[`TEMP_W-1:0];
        end
        `ADDR_EXT2_HI:
        begin
          s_d.limits[2].high = REG_REQ_IN.wdata[`TEMP_W-1:0];
        end
        `ADDR_EXT2_LO:
        begin
          s_d.limits[2].low = REG_REQ_IN.wdata[`TEMP_W-1:0];
        end
        default:
        begin
          // Read-only and unmapped addresses ignore writes
          s_d.rvalid = s_d.rvalid;
        end
      endcase
    end
    // Preset chosen by mode; per-port data lives elsewhere
    if (ANALOG_MODE_IN == `MODE_PRESET_TWO)
    begin
      s_d.preset_data = s_d.preset_two;
    end
    else if (ANALOG_MODE_IN == `MODE_PRESET_ONE)
    begin
      s_d.preset_data = s_d.preset_one;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      s_q.out_levels <= `RST_OUT_LEVELS;
      s_q.preset_one <= `RST_PRESET;
      s_q.preset_two <= `RST_PRESET;
      s_q.preset_data <= `RST_PRESET;
      s_q.avg_cfg <= `RST_AVG_CFG;
      // Limits reset wide open so no flag trips before setup
      s_q.limits <= {MONITORS{`RST_HI_LIMIT, `RST_LO_LIMIT}};
      s_q.rdata <= '0;
      s_q.rvalid <= 1'b0;
    end
    else if (CE_IN)
    begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA_OUT = s_q.rdata;
  assign REG_RVALID_OUT = s_q.rvalid;
  assign PRESET_DATA_OUT = s_q.preset_data;
  assign MONITOR_FLAGS_OUT = mon_flags;

  // ---------------------------------------------------------------
  // Port level mapping
  // ---------------------------------------------------------------
  // Pin-side levels are registered there, one cycle behind
  port_level_map #(
    .N(PORTS)
  ) u_ports (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .level_in(PORT_LEVEL_IN),
    .is_input_in(PORT_IS_INPUT_IN),
    .is_output_in(PORT_IS_OUTPUT_IN),
    .is_analog_in(PORT_IS_ANALOG_IN),
    .out_levels_in(s_q.out_levels),
    .preset_active_in(preset_active),
    .in_levels_out(in_levels),
    .drive_out(PORT_DRIVE_OUT),
    .oe_n_out(PORT_OE_N_OUT),
    .preset_out(PORT_PRESET_OUT)
  );

  // ---------------------------------------------------------------
  // Temperature monitors
  // ---------------------------------------------------------------
  // Averaging codes and limits are per monitor, in index order
  for (genvar m = 0; m < MONITORS; m++)
  begin : g_mon
    temp_limit_monitor u_mon (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CE_IN),
      .enable_in(MONITOR_ENABLE_IN[m]),
      .avg_code_in(s_q.avg_cfg[m*`AVG_CODE_W +: `AVG_CODE_W]),
      .limits_in(s_q.limits[m]),
      .sample_in(TEMP_SAMPLE_IN[m]),
      .result_out(mon_result[m]),
      .flags_out(mon_flags[m])
    );
  end
endmodule : io_data_and_temp_threshold_regs

// ---- rtl/io_regs_consts.svh ----
/*
  Offsets, field positions, reset values and widths of the I/O level
  and temperature limit register bank.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef IO_REGS_CONSTS_SVH
`define IO_REGS_CONSTS_SVH
`define TEMP_W 12
`define PORT_N 20
`define MON_N 3
`define REG_DW 16
`define REG_AW 5
`define LO_SPLIT 16
`define AVG_CODE_W 2
`define AVG_CNT_W 5
`define AVG_MIN_LOG2 3'h2
`define ADDR_IN_LO 5'h00
`define ADDR_IN_HI 5'h01
`define ADDR_OUT_LO 5'h02
`define ADDR_OUT_HI 5'h03
`define ADDR_PRESET_ONE 5'h04
`define ADDR_PRESET_TWO 5'h05
`define ADDR_AVG_CFG 5'h06
`define ADDR_INT_HI 5'h07
`define ADDR_INT_LO 5'h08
`define ADDR_EXT1_HI 5'h09
`define ADDR_EXT1_LO 5'h0a
`define ADDR_EXT2_HI 5'h0b
`define ADDR_EXT2_LO 5'h0c
`define ADDR_FLAGS 5'h0d
`define ADDR_RES_INT 5'h0e
`define ADDR_RES_EXT1 5'h0f
`define ADDR_RES_EXT2 5'h10
`define MODE_PRESET_ONE 2'h2
`define MODE_PRESET_TWO 2'h3
`define RST_HI_LIMIT 12'h7ff
`define RST_LO_LIMIT 12'h800
`define RST_PRESET 12'h000
`define RST_OUT_LEVELS 20'h00000
`define RST_AVG_CFG 6'h00
`endif

// ---- rtl/io_regs_pkg.sv ----
/*
  Types shared by the I/O level and temperature limit register bank.
  Assumes io_regs_consts.svh is on the include path.
*/
`include "io_regs_consts.svh"
package io_regs_pkg;
  typedef logic [`TEMP_W-1:0] temp_t;
  typedef struct packed {
    logic valid;
    temp_t value;
  } temp_sample_t;
  typedef struct packed {
    temp_t high;
    temp_t low;
  } temp_limits_t;
  typedef struct packed {
    logic high;
    logic low;
    logic fresh;
  } monitor_flags_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`REG_AW-1:0] addr;
    logic [`REG_DW-1:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic signed [`TEMP_W+4:0] acc;
    logic [`AVG_CNT_W-1:0] cnt;
    temp_t result;
    monitor_flags_t flags;
  } monitor_state_t;
endpackage : io_regs_pkg

// ---- rtl/temp_limit_monitor.sv ----
/*
  One temperature monitor: averages 4..32 samples, then compares the
  signed average against the high and low limits.
  Assumes samples arrive as one-cycle valid strobes.
*/
`timescale 1ns/1ps
`include "io_regs_consts.svh"
module temp_limit_monitor
  import io_regs_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic enable_in, // Monitor enable
  input wire logic [`AVG_CODE_W-1:0] avg_code_in, // Averaging code
  input wire temp_limits_t limits_in, // High and low limits
  input wire temp_sample_t sample_in, // Raw sample
  output temp_t result_out, // Last average
  output monitor_flags_t flags_out // Limit flags
);
  localparam int ACC_W = `TEMP_W + 5;
  monitor_state_t s_q;
  monitor_state_t s_d;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] avg;
  logic [`AVG_CNT_W-1:0] last_idx;
  logic [2:0] shamt;

  always_comb
  begin
    s_d = s_q;
    sum = s_q.acc + {{(ACC_W-`TEMP_W){sample_in.value[`TEMP_W-1]}},
      sample_in.value};
    last_idx = `AVG_CNT_W'((6'h04 << avg_code_in) - 6'h01);
    shamt = `AVG_MIN_LOG2 + 3'(avg_code_in);
    avg = sum >>> shamt;
    if (!enable_in)
    begin
      s_d.acc = '0;
      s_d.cnt = '0;
    end
    else if (sample_in.valid)
    begin
      // Closes at once if the code shrank mid-average
      if (s_q.cnt >= last_idx)
      begin
        s_d.result = avg[`TEMP_W-1:0];
        s_d.flags.fresh = 1'b1;
        s_d.flags.high = $signed(avg[`TEMP_W-1:0]) >
          $signed(limits_in.high);
        s_d.flags.low = $signed(avg[`TEMP_W-1:0]) <
          $signed(limits_in.low);
        s_d.acc = '0;
        s_d.cnt = '0;
      end
      else
      begin
        s_d.acc = sum;
        s_d.cnt = s_q.cnt + `AVG_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s_q <= '0;
    else if (ce_in)
      s_q <= s_d;
  end

  assign result_out = s_q.result;
  assign flags_out = s_q.flags;
endmodule : temp_limit_monitor

// ---- rtl/port_level_map.sv ----
/*
  Per-port level logic: samples input levels, drives output levels
  and marks analog-output ports that take the shared preset.
  Assumes port modes are steady levels from configuration logic.
*/
`timescale 1ns/1ps
module port_level_map #(
  parameter int N = 20
)
(
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic [N-1:0] level_in, // Pin levels
  input wire logic [N-1:0] is_input_in, // Input-mode ports
  input wire logic [N-1:0] is_output_in, // Output-mode ports
  input wire logic [N-1:0] is_analog_in, // Analog-out ports
  input wire logic [N-1:0] out_levels_in, // Output level bits
  input wire logic preset_active_in, // Preset mode selected
  output logic [N-1:0] in_levels_out, // Input level bits
  output logic [N-1:0] drive_out, // Pin drive level
  output logic [N-1:0] oe_n_out, // Pin enable, low drives
  output logic [N-1:0] preset_out // Port takes preset
);
  typedef struct packed {
    logic [N-1:0] in_levels;
    logic [N-1:0] drive;
    logic [N-1:0] oe_n;
    logic [N-1:0] preset;
  } port_state_t;

  port_state_t s_q;
  port_state_t s_d;

  for (genvar i = 0; i < N; i++)
  begin : g_port
    always_comb
    begin
      s_d.in_levels[i] = is_input_in[i] & level_in[i];
      s_d.drive[i] = is_output_in[i] & out_levels_in[i];
      s_d.oe_n[i] = ~is_output_in[i];
      s_d.preset[i] = is_analog_in[i] & preset_active_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s_q <= {{N{1'b0}}, {N{1'b0}}, {N{1'b1}}, {N{1'b0}}};
    else if (ce_in)
      s_q <= s_d;
  end

  assign in_levels_out = s_q.in_levels;
  assign drive_out = s_q.drive;
  assign oe_n_out = s_q.oe_n;
  assign preset_out = s_q.preset;
endmodule : port_level_map

// ---- verif/io_regs_asserts.sv ----
/*
  Port-level checker for the I/O level and temperature limit bank.
  Assumes it is bound to the top module.
*/
`timescale 1ns/1ps
`include "io_regs_consts.svh"
module io_regs_asserts
  import io_regs_pkg::*;
#(
  parameter int PORTS = 20,
  parameter int MONITORS = 3
)
(
  input wire logic CLK_IN, // Clock
  input wire logic RST_N_IN, // Async reset, active low
  input wire logic CE_IN, // Clock enable
  input wire reg_req_t REG_REQ_IN, // Register request
  input wire logic [`REG_DW-1:0] REG_RDATA_OUT, // Read data
  input wire logic REG_RVALID_OUT, // Read data valid
  input wire logic [PORTS-1:0] PORT_IS_OUTPUT_IN, // Output ports
  input wire logic [PORTS-1:0] PORT_IS_ANALOG_IN, // Analog ports
  input wire logic [PORTS-1:0] PORT_DRIVE_OUT, // Pin drive
  input wire logic [PORTS-1:0] PORT_OE_N_OUT, // Pin enable
  input wire logic [1:0] ANALOG_MODE_IN, // Analog mode
  input wire logic [PORTS-1:0] PORT_PRESET_OUT, // Preset ports
  input wire temp_sample_t [MONITORS-1:0] TEMP_SAMPLE_IN, // Samples
  input wire monitor_flags_t [MONITORS-1:0] MONITOR_FLAGS_OUT // Flags
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  a_read_answer: assert property (CE_IN && REG_REQ_IN.rd |=>
    REG_RVALID_OUT) else $error("read not answered");
  a_rvalid_cause: assert property (REG_RVALID_OUT && $past(CE_IN) |->
    $past(REG_REQ_IN.rd)) else $error("stray read valid");
  a_rdata_holds: assert property (!$past(REG_REQ_IN.rd) |->
    $stable(REG_RDATA_OUT)) else $error("read data moved");
  a_drive_gated: assert property (CE_IN |=>
    (PORT_DRIVE_OUT & ~$past(PORT_IS_OUTPUT_IN)) == '0)
    else $error("non-output port driven high");
  a_oe_output: assert property (CE_IN |=>
    PORT_OE_N_OUT == ~$past(PORT_IS_OUTPUT_IN))
    else $error("pin enable wrong");
  a_preset_ports: assert property (CE_IN |=>
    PORT_PRESET_OUT == ($past(PORT_IS_ANALOG_IN)
    & {PORTS{$past(ANALOG_MODE_IN[1])}})) else $error("preset ports wrong");
  a_int_flag_cause: assert property ($changed(MONITOR_FLAGS_OUT[0]) |->
    $past(TEMP_SAMPLE_IN[0].valid) || $past(TEMP_SAMPLE_IN[0].valid, 2))
    else $error("internal flags moved without sample");
  a_ext1_flag_cause: assert property ($changed(MONITOR_FLAGS_OUT[1]) |->
    $past(TEMP_SAMPLE_IN[1].valid) || $past(TEMP_SAMPLE_IN[1].valid, 2))
    else $error("first external flags moved without sample");
  a_ext2_flag_cause: assert property ($changed(MONITOR_FLAGS_OUT[2]) |->
    $past(TEMP_SAMPLE_IN[2].valid) || $past(TEMP_SAMPLE_IN[2].valid, 2))
    else $error("second external flags moved without sample");
endmodule : io_regs_asserts
bind io_data_and_temp_threshold_regs io_regs_asserts #(.PORTS(PORTS),
  .MONITORS(MONITORS)) u_io_regs_asserts (.CLK_IN(CLK_IN),
  .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .REG_REQ_IN(REG_REQ_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
  .PORT_IS_OUTPUT_IN(PORT_IS_OUTPUT_IN),
  .PORT_IS_ANALOG_IN(PORT_IS_ANALOG_IN), .PORT_DRIVE_OUT(PORT_DRIVE_OUT),
  .PORT_OE_N_OUT(PORT_OE_N_OUT), .ANALOG_MODE_IN(ANALOG_MODE_IN),
  .PORT_PRESET_OUT(PORT_PRESET_OUT), .TEMP_SAMPLE_IN(TEMP_SAMPLE_IN),
  .MONITOR_FLAGS_OUT(MONITOR_FLAGS_OUT));

// ---- verif/host_model.sv ----
/*
  Host side of the register port: one access at a time.
  Assumes reads are answered by a one-cycle valid pulse.
*/
`timescale 1ns/1ps
`include "io_regs_consts.svh"
module host_model
  import io_regs_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic rvalid_in, // Read data valid
  input wire logic [`REG_DW-1:0] rdata_in, // Read data
  output reg_req_t req_out // Register request
);
  initial req_out = '0;
  // Limit words are sent already in 12-bit two's complement form
  task automatic access(input logic wr, input logic [`REG_AW-1:0] a,
    input logic [`REG_DW-1:0] d, output logic [`REG_DW-1:0] q);
    int n;
    @(posedge clk_in);
    req_out <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '0;
    n = 0;
    while (!wr && !rvalid_in && n < 4)
    begin
      @(posedge clk_in);
      n++;
    end
    // An unanswered read hands back unknowns so the compare fails
    q = rvalid_in ? rdata_in : 'x;
  endtask : access
endmodule : host_model

// ---- verif/test_io_data_and_temp_threshold_regs.sv ----
/*
  Self-checking bench for the I/O level and temperature limit bank.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
`include "io_regs_consts.svh"
module test_io_data_and_temp_threshold_regs
  import io_regs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [2:0] en = 3'h7;
  reg_req_t req;
  logic [15:0] rdata;
  logic rvalid;
  logic [19:0] level = '0, is_in = '0, is_out = '0, is_an = '0;
  logic [19:0] drive, oe_n, preset;
  logic [1:0] mode = 2'h0;
  temp_t pdata;
  temp_sample_t [2:0] smp = '0;
  monitor_flags_t [2:0] flags;
  int n_mismatch = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  io_data_and_temp_threshold_regs u_io_data_and_temp_threshold_regs (
    .CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .REG_REQ_IN(req),
    .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .PORT_LEVEL_IN(level),
    .PORT_IS_INPUT_IN(is_in), .PORT_IS_OUTPUT_IN(is_out),
    .PORT_IS_ANALOG_IN(is_an), .PORT_DRIVE_OUT(drive),
    .PORT_OE_N_OUT(oe_n), .ANALOG_MODE_IN(mode), .PORT_PRESET_OUT(preset),
    .PRESET_DATA_OUT(pdata), .MONITOR_ENABLE_IN(en),
    .TEMP_SAMPLE_IN(smp), .MONITOR_FLAGS_OUT(flags));
  host_model u_host_model (.clk_in(clk), .rvalid_in(rvalid),
    .rdata_in(rdata), .req_out(req));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [4:0] a, logic [15:0] d);
    logic [15:0] q;
    u_host_model.access(1'b1, a, d, q);
  endtask : wr
  task automatic chk_rd(logic [4:0] a, logic [15:0] exp);
    logic [15:0] q;
    u_host_model.access(1'b0, a, 16'h0000, q);
    chk($sformatf("reg %h", a), 20'(exp), 20'(q));
  endtask : chk_rd
  task automatic t_reset_values();
    for (int a = 2; a < 13; a++)
      chk_rd(5'(a), a < 7 ? 16'h0000 : a[0] ? 16'h07ff : 16'h0800);
    chk_rd(5'h1f, 16'h0000);
  endtask : t_reset_values
  task automatic t_out_levels();
    is_out <= 20'h0ffff;
    wr(`ADDR_OUT_LO, 16'ha5c3);
    wr(`ADDR_OUT_HI, 16'hfff9);
    chk_rd(`ADDR_OUT_LO, 16'ha5c3);
    chk_rd(`ADDR_OUT_HI, 16'h0009);
    repeat (2) @(posedge clk);
    chk("drive", 20'h0a5c3, drive);
    chk("oe_n", 20'hf0000, oe_n);
    ce <= 1'b0;
    is_out <= '0;
    repeat (3) @(posedge clk);
    chk("drive frozen", 20'h0a5c3, drive);
    chk("oe_n frozen", 20'hf0000, oe_n);
    ce <= 1'b1;
  endtask : t_out_levels
  task automatic t_in_levels();
    is_out <= '0;
    is_in <= 20'hfff0f;
    level <= 20'h53c96;
    wr(`ADDR_IN_LO, 16'hffff);
    chk_rd(`ADDR_IN_LO, 16'h3c06);
    chk_rd(`ADDR_IN_HI, 16'h0005);
  endtask : t_in_levels
  task automatic t_presets();
    is_an <= 20'hfffff;
    wr(`ADDR_PRESET_ONE, 16'hfabc);
    wr(`ADDR_PRESET_TWO, 16'h0123);
    chk_rd(`ADDR_PRESET_ONE, 16'h0abc);
    chk_rd(`ADDR_PRESET_TWO, 16'h0123);
    for (int m = 2; m < 4; m++)
    begin
      mode <= 2'(m);
      repeat (3) @(posedge clk);
      chk("preset ports", 20'hfffff, preset);
      chk("preset data", m == 2 ? 20'h00abc : 20'h00123, 20'(pdata));
    end
    mode <= 2'h1;
    repeat (3) @(posedge clk);
    chk("preset off", 20'h00000, preset);
  endtask : t_presets
  task automatic send(int lo, int hi);
    for (int i = lo; i < hi; i++)
    begin
      @(posedge clk);
      smp[0] <= '{valid: i < 4, value: 12'h020};
      smp[1] <= '{valid: i < 16, value: 12'hfe0};
      smp[2] <= '{valid: i < 8, value: 12'h123};
    end
    @(posedge clk);
    smp <= '0;
    repeat (3) @(posedge clk);
  endtask : send
  task automatic t_monitors();
    wr(`ADDR_AVG_CFG, 16'h0018);
    chk_rd(`ADDR_AVG_CFG, 16'h0018);
    wr(`ADDR_INT_HI, 16'h0010);
    wr(`ADDR_INT_LO, 16'h0ff0);
    wr(`ADDR_EXT1_LO, 16'h0ff8);
    send(0, 3);
    chk("flags early", 20'h0, 20'(flags));
    send(3, 16);
    chk("int flags", 20'h5, 20'(flags[0]));
    chk("ext1 flags", 20'h3, 20'(flags[1]));
    chk("ext2 flags", 20'h1, 20'(flags[2]));
    chk_rd(`ADDR_FLAGS, 16'h005d);
    chk_rd(`ADDR_RES_INT, 16'h0020);
    chk_rd(`ADDR_RES_EXT1, 16'h0fe0);
    chk_rd(`ADDR_RES_EXT2, 16'h0123);
  endtask : t_monitors
  task automatic t_enables();
    wr(`ADDR_INT_HI, 16'h0020);
    wr(`ADDR_INT_LO, 16'h0021);
    wr(`ADDR_EXT1_HI, 16'h0fdf);
    wr(`ADDR_EXT2_HI, 16'h0122);
    wr(`ADDR_EXT2_LO, 16'h0124);
    en <= 3'h0;
    send(0, 16);
    chk("flags held", 20'h0005d, 20'(flags));
    en <= 3'h7;
    send(0, 16);
    chk("int flags low", 20'h3, 20'(flags[0]));
    chk("ext1 flags high", 20'h7, 20'(flags[1]));
    chk("ext2 flags both", 20'h7, 20'(flags[2]));
  endtask : t_enables
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_out_levels();
    t_in_levels();
    t_presets();
    t_monitors();
    t_enables();
    test_done();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end
endmodule : test_io_data_and_temp_threshold_regs
